// ---- sfpf_pkg.sv ----
// Package: constants and types for the serial flash protect front end
// How it works
// - Top select 0: levels 1-7 protect highest 1..64 blocks, ending at 127
// - Top select 1: levels 1-7 protect lowest 1..64 blocks, starting at 0
// - Level bit 3 set protects all 128 blocks, whatever the top select
// - Chip erase runs only when all four level bits are zero
// - Secured OTP of 4K bits; security bit 0 shows factory lock
// - Security write command sets customer lock, security bit 1
// - Factory or customer lock, once set, clears only on reset; locked OTP stays
// - In OTP mode every main array access is refused
// - OTP 000h-00Fh holds serial number, 010h-1FFh customer content
// - Array 000000h-7FFFFFh; individual locks act on 64KB blocks
// - Lowest and highest blocks lock per 4KB sector, 16 each
// - Invalid command: standby, output off, until next select fall
// - Valid command: active until next select rise
// - Bits sampled on serial clock rise, driven on serial clock fall
// - Serial clock modes 0 and 3 both work
// - Write-type commands must end on a byte boundary, else rejected
// - Array access ignored while an internal write operation runs
// - Write enable latch needed; cleared by disable and write completion
// - Deep power-down accepts only power-down release; signature read is never decoded
package sfpf_pkg;
	localparam int ADDR_W = 23;
	localparam int LEVEL_W = 4;
	localparam int UNITS = 158;
	localparam int UNIT_W = 8;
	localparam logic [7:0] BLOCKS_ALL = 8'h80;
	localparam logic [6:0] BLOCK_TOP = 7'h7F;
	localparam logic [7:0] UNIT_MID_BASE = 8'h0F;
	localparam logic [7:0] UNIT_TOP_BASE = 8'h8E;
	localparam logic [8:0] OTP_CUST_BASE = 9'h010;
	localparam int SEC_FACTORY_BIT = 0;
	localparam int SEC_CUSTOMER_BIT = 1;
	localparam logic CS_IDLE = 1'b1;
	// Opcodes of the array commands
	localparam logic [7:0] CODE_READ = 8'h03;
	localparam logic [7:0] CODE_FAST_READ = 8'h0B;
	localparam logic [7:0] CODE_STATUS_READ = 8'h05;
	localparam logic [7:0] CODE_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CODE_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CODE_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CODE_PAGE_PROG = 8'h02;
	localparam logic [7:0] CODE_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CODE_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] CODE_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] CODE_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] CODE_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] CODE_POWER_DOWN = 8'hB9;
	localparam logic [7:0] CODE_POWER_DOWN_RELEASE = 8'hAB;
	// Opcodes of the protection and OTP commands
	localparam logic [7:0] CODE_OTP_ENTER = 8'hF1;
	localparam logic [7:0] CODE_OTP_EXIT = 8'hF2;
	localparam logic [7:0] CODE_SEC_READ = 8'hF3;
	localparam logic [7:0] CODE_SEC_WRITE = 8'hF4;
	localparam logic [7:0] CODE_INDIV_SELECT = 8'hF5;
	localparam logic [7:0] CODE_UNIT_LOCK = 8'hF6;
	localparam logic [7:0] CODE_UNIT_UNLOCK = 8'hF7;
	localparam logic [7:0] CODE_ALL_LOCK = 8'hF8;
	localparam logic [7:0] CODE_ALL_UNLOCK = 8'hF9;

	typedef enum logic [4:0] {
		OP_NONE, OP_READ, OP_FAST_READ, OP_STATUS_READ, OP_SEC_READ, OP_SIGNATURE_READ,
		OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_STATUS_WRITE, OP_PAGE_PROG,
		OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE,
		OP_POWER_DOWN, OP_POWER_DOWN_RELEASE, OP_OTP_ENTER, OP_OTP_EXIT,
		OP_SEC_WRITE, OP_INDIV_SELECT, OP_UNIT_LOCK, OP_UNIT_UNLOCK,
		OP_ALL_LOCK, OP_ALL_UNLOCK
	} sfpf_op_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_OPC, ST_ADDR, ST_DATA_IN, ST_DATA_OUT, ST_STANDBY
	} sfpf_state_t;

	typedef struct packed {
		logic             cs_n;
		logic             sclk;
		logic             si;
	} sfpf_pins_t;

	typedef struct packed {
		logic             valid;
		sfpf_op_t         op;
		logic             otp;
		logic [ADDR_W-1:0] addr;
	} sfpf_exec_t;

	typedef struct packed {
		logic             valid;
		logic [7:0]       data;
	} sfpf_byte_t;
endpackage : sfpf_pkg

// ---- sfpf_protect_map.sv ----
// Address to protection lookup: level field, top select and unit locks
`timescale 1ns/1ns
`default_nettype none
module sfpf_protect_map (
	// Protection settings
	input  wire logic [sfpf_pkg::LEVEL_W-1:0] level_in,
	input  wire logic                         top_bottom_select_in,
	input  wire logic                         indiv_in,
	input  wire logic [sfpf_pkg::UNITS-1:0]   unit_lock_in,
	// Target address
	input  wire logic [sfpf_pkg::ADDR_W-1:0]  addr_in,
	// Results
	output logic      [sfpf_pkg::UNIT_W-1:0]  unit_idx_out,
	output logic                              protected_out,
	output logic                              any_lock_out
);
	import sfpf_pkg::*;

	logic [6:0] blk;
	logic [3:0] sect;
	logic [7:0] span;
	logic       level_hit;

	always_comb
	begin
		blk = addr_in[ADDR_W-1:16];
		sect = addr_in[15:12];
		// Blocks covered by levels 1-7: 1, 2, 4 ... 64
		span = (level_in[2:0] == 3'h0) ? 8'h00 : (8'h01 << (level_in[2:0] - 3'h1));
		if (level_in[3])
			level_hit = 1'b1;
		else if (top_bottom_select_in)
			level_hit = ({1'b0, blk} < span);
		else
			level_hit = (span != 8'h00) && ({1'b0, blk} >= (BLOCKS_ALL - span));
		// Edge blocks lock per sector, the rest per block
		if (blk == 7'h00)
			unit_idx_out = {4'h0, sect};
		else if (blk == BLOCK_TOP)
			unit_idx_out = UNIT_TOP_BASE + {4'h0, sect};
		else
			unit_idx_out = {1'b0, blk} + UNIT_MID_BASE;
		// Individual mode replaces the level field here; chip erase still checks the level field
		protected_out = indiv_in ? unit_lock_in[unit_idx_out] : level_hit;
		any_lock_out = indiv_in & (|unit_lock_in);
	end
endmodule : sfpf_protect_map
`default_nettype wire

// ---- sfpf_frontend.sv ----
// Serial flash command front end with write protection and secured OTP
`timescale 1ns/1ns
`default_nettype none
module sfpf_frontend (
	// Clock and reset
	input  wire logic                          mclk_in,
	input  wire logic                          rst_n_in,
	// Serial pins from the host
	input  wire sfpf_pkg::sfpf_pins_t          pins_in,
	output logic                               so_out,
	output logic                               so_oe_out,
	// Status bits kept by the core
	input  wire logic [sfpf_pkg::LEVEL_W-1:0]  protect_level_in,
	input  wire logic                          top_bottom_select_in,
	input  wire logic                          busy_in,
	input  wire logic                          factory_lock_in,
	// Commands handed to the core
	output sfpf_pkg::sfpf_exec_t               exec_out,
	output sfpf_pkg::sfpf_byte_t               data_byte_out,
	output logic                               reject_out,
	// Front end state
	output logic                               write_enable_latch_out,
	output logic                               otp_mode_out,
	output logic                               power_down_out,
	output logic                               indiv_mode_out,
	output logic                               active_out,
	output logic [7:0]                         sec_reg_out
);
	import sfpf_pkg::*;

	typedef struct packed {
		sfpf_state_t        st;
		logic [2:0]         cs_s;
		logic [2:0]         sclk_s;
		logic [2:0]         si_s;
		logic               cs_f;
		logic               sclk_f;
		logic               si_f;
		logic [7:0]         shreg;
		logic [23:0]        addr;
		logic [2:0]         bit_idx;
		logic [1:0]         byte_idx;
		sfpf_op_t           op;
		logic [7:0]         out_sh;
		logic               so;
		logic               so_oe;
		logic               write_enable_latch;
		logic               otp_mode;
		logic               pd;
		logic               indiv;
		logic               fact_lock;
		logic               cust_lock;
		logic               strap_done;
		logic               active;
		logic               reject;
		logic [UNITS-1:0]   unit_lock;
		sfpf_exec_t         exec;
		sfpf_byte_t         dbyte;
	} sfpf_core_t;

	sfpf_core_t          r;
	sfpf_core_t          n;
	logic                cs_now;
	logic                sclk_now;
	logic                si_now;
	logic                cs_fall;
	logic                cs_rise;
	logic                sclk_rise;
	logic                sclk_fall;
	logic [7:0]          byte_in;
	sfpf_op_t            dec_op;
	logic                ok;
	logic                otp_locked;
	logic                prot_hit;
	logic                any_lock;
	logic [UNIT_W-1:0]   unit_idx;

	function automatic sfpf_op_t decode(input logic [7:0] code);
		case (code)
			CODE_READ:               decode = OP_READ;
			CODE_FAST_READ:          decode = OP_FAST_READ;
			CODE_STATUS_READ:        decode = OP_STATUS_READ;
			CODE_STATUS_WRITE:       decode = OP_STATUS_WRITE;
			CODE_WRITE_ENABLE:       decode = OP_WRITE_ENABLE;
			CODE_WRITE_DISABLE:      decode = OP_WRITE_DISABLE;
			CODE_PAGE_PROG:          decode = OP_PAGE_PROG;
			CODE_SECTOR_ERASE:       decode = OP_SECTOR_ERASE;
			CODE_BLOCK32_ERASE:      decode = OP_BLOCK32_ERASE;
			CODE_BLOCK_ERASE:        decode = OP_BLOCK_ERASE;
			CODE_CHIP_ERASE_A:       decode = OP_CHIP_ERASE;
			CODE_CHIP_ERASE_B:       decode = OP_CHIP_ERASE;
			CODE_POWER_DOWN:         decode = OP_POWER_DOWN;
			CODE_POWER_DOWN_RELEASE: decode = OP_POWER_DOWN_RELEASE;
			CODE_OTP_ENTER:          decode = OP_OTP_ENTER;
			CODE_OTP_EXIT:           decode = OP_OTP_EXIT;
			CODE_SEC_READ:           decode = OP_SEC_READ;
			CODE_SEC_WRITE:          decode = OP_SEC_WRITE;
			CODE_INDIV_SELECT:       decode = OP_INDIV_SELECT;
			CODE_UNIT_LOCK:          decode = OP_UNIT_LOCK;
			CODE_UNIT_UNLOCK:        decode = OP_UNIT_UNLOCK;
			CODE_ALL_LOCK:           decode = OP_ALL_LOCK;
			CODE_ALL_UNLOCK:         decode = OP_ALL_UNLOCK;
			default:                 decode = OP_NONE;
		endcase
	endfunction : decode

	function automatic logic has_addr(input sfpf_op_t op);
		has_addr = (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_PAGE_PROG) ||
			(op == OP_SECTOR_ERASE) || (op == OP_BLOCK32_ERASE) ||
			(op == OP_BLOCK_ERASE) || (op == OP_UNIT_LOCK) || (op == OP_UNIT_UNLOCK);
	endfunction : has_addr

	function automatic logic is_erase(input sfpf_op_t op);
		is_erase = (op == OP_SECTOR_ERASE) || (op == OP_BLOCK32_ERASE) ||
			(op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE);
	endfunction : is_erase

	function automatic logic needs_wel(input sfpf_op_t op);
		needs_wel = is_erase(op) || (op == OP_PAGE_PROG) || (op == OP_STATUS_WRITE) ||
			(op == OP_SEC_WRITE) || (op == OP_INDIV_SELECT) || (op == OP_UNIT_LOCK) ||
			(op == OP_UNIT_UNLOCK) || (op == OP_ALL_LOCK) || (op == OP_ALL_UNLOCK);
	endfunction : needs_wel

	function automatic logic is_lock(input sfpf_op_t op);
		is_lock = (op == OP_UNIT_LOCK) || (op == OP_UNIT_UNLOCK) ||
			(op == OP_ALL_LOCK) || (op == OP_ALL_UNLOCK);
	endfunction : is_lock

	sfpf_protect_map u_map (
		.level_in             (protect_level_in),
		.top_bottom_select_in (top_bottom_select_in),
		.indiv_in             (r.indiv),
		.unit_lock_in         (r.unit_lock),
		.addr_in              (r.addr[ADDR_W-1:0]),
		.unit_idx_out         (unit_idx),
		.protected_out        (prot_hit),
		.any_lock_out         (any_lock)
	);

	always_comb
	begin
		n = r;
		n.exec.valid = 1'b0;
		n.dbyte.valid = 1'b0;
		n.reject = 1'b0;
		// First stage feeds only the second
		n.cs_s = {r.cs_s[1:0], pins_in.cs_n};
		n.sclk_s = {r.sclk_s[1:0], pins_in.sclk};
		n.si_s = {r.si_s[1:0], pins_in.si};
		cs_now = (r.cs_s[1] == r.cs_s[2]) ? r.cs_s[2] : r.cs_f;
		sclk_now = (r.sclk_s[1] == r.sclk_s[2]) ? r.sclk_s[2] : r.sclk_f;
		si_now = (r.si_s[1] == r.si_s[2]) ? r.si_s[2] : r.si_f;
		n.cs_f = cs_now;
		n.sclk_f = sclk_now;
		n.si_f = si_now;
		cs_fall = r.cs_f & ~cs_now;
		cs_rise = ~r.cs_f & cs_now;
		// Edges count only inside a frame, so idle level is free
		sclk_rise = ~r.sclk_f & sclk_now & ~cs_now & ~r.cs_f;
		sclk_fall = r.sclk_f & ~sclk_now & ~cs_now & ~r.cs_f;
		byte_in = {r.shreg[6:0], si_now};
		dec_op = decode(byte_in);
		ok = 1'b0;
		// Customer lock closes the whole region, factory lock the serial number
		otp_locked = r.cust_lock |
			(r.fact_lock & (r.addr[8:0] < OTP_CUST_BASE));
		// Strap is caught once after reset release
		if (!r.strap_done)
		begin
			n.strap_done = 1'b1;
			n.fact_lock = r.fact_lock | factory_lock_in;
		end

		case (r.st)
			ST_IDLE, ST_STANDBY:
			begin
				if (cs_fall)
				begin
					n.st = ST_OPC;
					n.bit_idx = 3'h0;
					n.byte_idx = 2'h0;
				end
			end
			ST_OPC:
			begin
				if (sclk_rise)
				begin
					n.shreg = byte_in;
					n.bit_idx = r.bit_idx + 3'h1;
					if (r.bit_idx == 3'h7)
					begin
						n.op = dec_op;
						if ((dec_op == OP_NONE) ||
							(r.pd && (dec_op != OP_POWER_DOWN_RELEASE) &&
							(dec_op != OP_SIGNATURE_READ)) ||
							(busy_in && ((dec_op == OP_READ) || (dec_op == OP_FAST_READ))))
						begin
							n.st = ST_STANDBY;
							n.reject = 1'b1;
						end
						else if (has_addr(dec_op))
							n.st = ST_ADDR;
						else if ((dec_op == OP_STATUS_READ) || (dec_op == OP_SEC_READ) ||
							(dec_op == OP_SIGNATURE_READ))
						begin
							n.st = ST_DATA_OUT;
							n.exec = '{1'b1, dec_op, r.otp_mode, '0};
							n.out_sh = {6'h00, r.cust_lock, r.fact_lock};
							n.so_oe = (dec_op == OP_SEC_READ);
							if (dec_op == OP_SIGNATURE_READ)
								n.pd = 1'b0;
						end
						else
							n.st = ST_DATA_IN;
					end
				end
			end
			ST_ADDR:
			begin
				if (sclk_rise)
				begin
					n.addr = {r.addr[22:0], si_now};
					n.bit_idx = r.bit_idx + 3'h1;
					if (r.bit_idx == 3'h7)
					begin
						n.byte_idx = r.byte_idx + 2'h1;
						if (r.byte_idx == 2'h2)
						begin
							n.byte_idx = 2'h0;
							if ((r.op == OP_READ) || (r.op == OP_FAST_READ))
							begin
								n.st = ST_DATA_OUT;
								// OTP mode steers reads away from the array
								n.exec = '{1'b1, r.op, r.otp_mode,
									n.addr[ADDR_W-1:0]};
							end
							else
								n.st = ST_DATA_IN;
						end
					end
				end
			end
			ST_DATA_IN:
			begin
				if (sclk_rise)
				begin
					n.shreg = byte_in;
					n.bit_idx = r.bit_idx + 3'h1;
					if ((r.bit_idx == 3'h7) &&
						((r.op == OP_PAGE_PROG) || (r.op == OP_STATUS_WRITE)))
						n.dbyte = '{1'b1, byte_in};
				end
			end
			ST_DATA_OUT:
			begin
				if (sclk_fall && r.so_oe)
				begin
					n.so = r.out_sh[7];
					n.out_sh = {r.out_sh[6:0], r.out_sh[7]};
				end
			end
			default:
				n.st = ST_IDLE;
		endcase

		if (cs_rise)
		begin
			// Reads may stop anywhere in the data phase; writes are judged here
			n.st = ST_IDLE;
			n.so_oe = 1'b0;
			if (r.st == ST_DATA_IN)
			begin
				ok = (r.bit_idx == 3'h0);
				if (needs_wel(r.op) && !r.write_enable_latch)
					ok = 1'b0;
				if (needs_wel(r.op) && busy_in)
					ok = 1'b0;
				if (r.pd && (r.op != OP_POWER_DOWN_RELEASE))
					ok = 1'b0;
				if (r.otp_mode && (is_erase(r.op) || is_lock(r.op) ||
					(r.op == OP_STATUS_WRITE) || (r.op == OP_INDIV_SELECT)))
					ok = 1'b0;
				if (r.otp_mode && (r.op == OP_PAGE_PROG) && otp_locked)
					ok = 1'b0;
				if (!r.otp_mode && prot_hit && ((r.op == OP_PAGE_PROG) ||
					(r.op == OP_SECTOR_ERASE) || (r.op == OP_BLOCK32_ERASE) ||
					(r.op == OP_BLOCK_ERASE)))
					ok = 1'b0;
				if ((r.op == OP_CHIP_ERASE) && ((protect_level_in != '0) || any_lock))
					ok = 1'b0;
				if (is_lock(r.op) && !r.indiv)
					ok = 1'b0;
				if (ok)
				begin
					n.exec = '{1'b1, r.op, r.otp_mode, r.addr[ADDR_W-1:0]};
					if (needs_wel(r.op))
						n.write_enable_latch = 1'b0;
					case (r.op)
						OP_WRITE_ENABLE:        n.write_enable_latch = 1'b1;
						OP_WRITE_DISABLE:       n.write_enable_latch = 1'b0;
						OP_POWER_DOWN:          n.pd = 1'b1;
						OP_POWER_DOWN_RELEASE:  n.pd = 1'b0;
						OP_OTP_ENTER:           n.otp_mode = 1'b1;
						OP_OTP_EXIT:            n.otp_mode = 1'b0;
						OP_SEC_WRITE:           n.cust_lock = 1'b1;
						OP_INDIV_SELECT:        n.indiv = 1'b1;
						OP_UNIT_LOCK:           n.unit_lock[unit_idx] = 1'b1;
						OP_UNIT_UNLOCK:         n.unit_lock[unit_idx] = 1'b0;
						OP_ALL_LOCK:            n.unit_lock = '1;
						OP_ALL_UNLOCK:          n.unit_lock = '0;
						default:                n.op = r.op;
					endcase
				end
				else
					n.reject = 1'b1;
			end
			else if ((r.st == ST_OPC && r.bit_idx != 3'h0) || (r.st == ST_ADDR))
				n.reject = 1'b1;
		end
		// Opcode still shifting is not yet a valid command
		n.active = (n.st == ST_ADDR) || (n.st == ST_DATA_IN) || (n.st == ST_DATA_OUT);
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			r <= '0;
			r.cs_s <= {3{CS_IDLE}};
			r.cs_f <= CS_IDLE;
		end
		else
			r <= n;
	end

	assign so_out = r.so;
	assign so_oe_out = r.so_oe;
	assign exec_out = r.exec;
	assign data_byte_out = r.dbyte;
	assign reject_out = r.reject;
	assign write_enable_latch_out = r.write_enable_latch;
	assign otp_mode_out = r.otp_mode;
	assign power_down_out = r.pd;
	assign indiv_mode_out = r.indiv;
	assign active_out = r.active;
	assign sec_reg_out = {6'h00, r.cust_lock, r.fact_lock};

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_write_done;
		exec_out.valid && needs_wel(exec_out.op);
	endsequence
	sequence s_sec_bit_out;
		sclk_fall && r.so_oe ##1 1'b1;
	endsequence

	a_chip_erase_gate: assert property (exec_out.valid && exec_out.op == OP_CHIP_ERASE
		|-> $past(protect_level_in) == 4'h0) else $error("chip erase with level set");
	a_otp_no_erase: assert property (exec_out.valid && is_erase(exec_out.op)
		|-> !exec_out.otp) else $error("erase while in OTP mode");
	a_locks_stay: assert property ($past(r.fact_lock) || $past(r.cust_lock)
		|-> sec_reg_out[1:0] >= $past(sec_reg_out[1:0])
		&& (sec_reg_out[1:0] & $past(sec_reg_out[1:0])) == $past(sec_reg_out[1:0]))
		else $error("lock bit cleared");
	a_sec_write_lock: assert property (exec_out.valid && exec_out.op == OP_SEC_WRITE
		|-> sec_reg_out[SEC_CUSTOMER_BIT] ##1 sec_reg_out[SEC_CUSTOMER_BIT])
		else $error("customer lock not set");
	a_standby_quiet: assert property (r.st == ST_STANDBY |-> !so_oe_out && !active_out)
		else $error("output on in standby");
	a_byte_boundary: assert property (exec_out.valid && needs_wel(exec_out.op)
		|-> $past(r.bit_idx) == 3'h0 && $past(cs_rise)) else $error("off boundary");
	a_busy_ignore: assert property (s_write_done |-> !$past(busy_in))
		else $error("write taken while busy");
	a_wel_cleared: assert property (s_write_done |-> !write_enable_latch_out
		&& $past(write_enable_latch_out)) else $error("latch not cleared");
	a_pd_filter: assert property (exec_out.valid && $past(r.pd)
		|-> exec_out.op inside {OP_POWER_DOWN_RELEASE, OP_SIGNATURE_READ})
		else $error("command taken in power-down");
	a_prot_write: assert property (exec_out.valid && !exec_out.otp
		&& exec_out.op inside {OP_PAGE_PROG, OP_SECTOR_ERASE, OP_BLOCK_ERASE}
		|-> !$past(prot_hit)) else $error("write into protected area");
	a_so_on_fall: assert property (so_oe_out && $changed(so_out) |-> $past(sclk_fall))
		else $error("output moved off falling edge");
	a_sec_bit_order: assert property (s_sec_bit_out |-> so_out == $past(r.out_sh[7]))
		else $error("security bit order wrong");
endmodule : sfpf_frontend
`default_nettype wire

// ---- sfpf_host_model.sv ----
// Host serial controller model driving chip select, serial clock and data
`timescale 1ns/1ns
`default_nettype none
module sfpf_host_model (
	// Clock and returned data
	input  wire logic            mclk_in,
	input  wire logic            so_in,
	// Pins to the device
	output sfpf_pkg::sfpf_pins_t pins_out
);
	import sfpf_pkg::*;
	logic idle_hi_r;

	initial
	begin
		idle_hi_r = 1'b0;
		pins_out = '{cs_n: CS_IDLE, sclk: 1'b0, si: 1'b0};
	end

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : tick

	// Idle level of the clock; changed only while deselected
	task automatic set_mode(input logic hi);
		idle_hi_r = hi;
		pins_out.sclk = hi;
		tick(8);
	endtask : set_mode

	// Data changes while the clock is low and is read back late in the high phase
	task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx, output logic [7:0] rx);
		rx = 8'h00;
		pins_out.cs_n = 1'b0;
		tick(4);
		for (int i = 0; i < ntx + nrx; i++)
		begin
			pins_out.sclk = 1'b0;
			pins_out.si = (i < ntx) ? tx[39 - i] : i[0];
			tick(4);
			pins_out.sclk = 1'b1;
			tick(4);
			if (i >= ntx)
				rx = {rx[6:0], so_in};
		end
		pins_out.sclk = idle_hi_r;
		tick(4);
		pins_out.cs_n = CS_IDLE;
		// Released data line must not keep its last value
		pins_out.si = ~pins_out.si;
		tick(8);
	endtask : xfer
endmodule : sfpf_host_model
`default_nettype wire

// ---- sfpf_tb.sv ----
// Self-checking bench for the serial flash protect front end
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import sfpf_pkg::*;
	logic       mclk_in, rst_n_in, busy, fact, tbs, act_seen, so, so_oe, rj, write_enable_latch, otp, act;
	logic [3:0] lvl;
	logic [7:0] sec, rx, db_r;
	logic       pdn, indv;
	sfpf_byte_t db;
	sfpf_pins_t pins;
	sfpf_exec_t ex, ex_r;
	int         err_total, check_count, ex_cnt, rj_cnt, n, blk;

	sfpf_frontend sfpf_frontend_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pins_in(pins),
		.so_out(so), .so_oe_out(so_oe), .protect_level_in(lvl), .top_bottom_select_in(tbs),
		.busy_in(busy), .factory_lock_in(fact), .exec_out(ex), .data_byte_out(db),
		.reject_out(rj), .write_enable_latch_out(write_enable_latch), .otp_mode_out(otp),
		.power_down_out(pdn), .indiv_mode_out(indv), .active_out(act), .sec_reg_out(sec));
	sfpf_host_model sfpf_host_model_i (.mclk_in(mclk_in), .so_in(so), .pins_out(pins));

	initial
		mclk_in = 1'b0;
	always #25 mclk_in = ~mclk_in;

	always @(posedge mclk_in)
	begin
		if (ex.valid === 1'b1)
		begin
			ex_r = ex;
			ex_cnt++;
		end
		if (rj === 1'b1)
			rj_cnt++;
		if (db.valid === 1'b1)
			db_r = db.data;
		if (act === 1'b1)
			act_seen = 1'b1;
	end

	task automatic finish_test();
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	// Negative reject expectation means the pulse is not judged
	task automatic run(input logic [39:0] tx, input int nb, input int e, input int r);
		int         e0;
		int         r0;
		logic [7:0] d;
		e0 = ex_cnt;
		r0 = rj_cnt;
		sfpf_host_model_i.xfer(tx, nb, 0, d);
		chk("exec count", e, ex_cnt - e0);
		if (r >= 0)
			chk("reject count", r, rj_cnt - r0);
	endtask : run

	task automatic c8(input logic [7:0] op, input int e, input int r);
		run({op, 32'h0}, 8, e, r);
	endtask : c8

	function automatic logic prot(input logic [3:0] l, input logic t, input int b);
		int k;
		k = (l[2:0] == 3'h0) ? 0 : (1 << (l[2:0] - 1));
		if (l[3])
			return 1'b1;
		return t ? (b < k) : (b >= 128 - k);
	endfunction : prot

	task automatic wr_otp(input logic [23:0] a, input int e);
		c8(CODE_OTP_ENTER, 1, 0);
		c8(CODE_WRITE_ENABLE, 1, 0);
		run({CODE_PAGE_PROG, a, 8'hA5}, 40, e, 1 - e);
		if (e)
			chk("otp target", 1, ex_r.otp);
		c8(CODE_OTP_EXIT, 1, 0);
	endtask : wr_otp

	initial
	begin
		repeat (90000) @(posedge mclk_in);
		err_total++;
		finish_test();
	end

	initial
	begin
		{err_total, check_count, ex_cnt, rj_cnt} = '0;
		{rst_n_in, busy, fact, tbs, act_seen, lvl} = '0;
		repeat (20) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (8) @(negedge mclk_in);
		chk("latch after reset", 0, write_enable_latch);
		run({CODE_PAGE_PROG, 24'h000100, 8'h5A}, 40, 0, 1);
		c8(CODE_WRITE_ENABLE, 1, 0);
		chk("latch set", 1, write_enable_latch);
		c8(CODE_WRITE_DISABLE, 1, 0);
		chk("latch cleared", 0, write_enable_latch);
		c8(CODE_WRITE_ENABLE, 1, 0);
		run({CODE_SECTOR_ERASE, 24'h001000, 8'h0}, 31, 0, 1);
		// Innermost protected and outermost free block of levels 0-8 and 15, both ends
		for (int t = 0; t < 2; t++)
			for (int l = 0; l < 10; l++)
				for (int k = 0; k < 2; k++)
				begin
					tbs = t[0];
					lvl = (l == 9) ? 4'hF : l[3:0];
					n = (lvl[2:0] == 3'h0) ? 0 : (1 << (lvl[2:0] - 1));
					blk = (t == 1 ? n - 1 + k : 128 - n - k) & 127;
					c8(CODE_WRITE_ENABLE, 1, 0);
					run({CODE_SECTOR_ERASE, 24'(blk << 16), 8'h0}, 32, !prot(lvl, tbs, blk),
						prot(lvl, tbs, blk));
					if (!prot(lvl, tbs, blk))
						chk("erase address", blk << 16, ex_r.addr);
				end
		tbs = 1'b0;
		lvl = 4'h1;
		c8(CODE_WRITE_ENABLE, 1, 0);
		c8(CODE_CHIP_ERASE_A, 0, 1);
		lvl = 4'h0;
		c8(CODE_WRITE_ENABLE, 1, 0);
		c8(CODE_CHIP_ERASE_B, 1, 0);
		chk("chip erase op", OP_CHIP_ERASE, ex_r.op);
		c8(CODE_STATUS_READ, 1, 0);
		busy = 1'b1;
		c8(CODE_WRITE_ENABLE, 1, 0);
		run({CODE_SECTOR_ERASE, 24'h001000, 8'h0}, 32, 0, 1);
		run({CODE_READ, 24'h000100, 8'h0}, 32, 0, -1);
		busy = 1'b0;
		c8(CODE_POWER_DOWN, 1, 0);
		chk("power down", 1, pdn);
		c8(CODE_WRITE_ENABLE, 0, 1);
		c8(CODE_POWER_DOWN_RELEASE, 1, 0);
		chk("power down left", 0, pdn);
		act_seen = 1'b0;
		c8(8'h77, 0, 1);
		chk("active on bad code", 0, act_seen);
		chk("output enable", 0, so_oe);
		c8(CODE_OTP_ENTER, 1, 0);
		chk("otp mode", 1, otp);
		run({CODE_READ, 24'h000100, 8'h0}, 32, 1, 0);
		chk("otp read target", 1, ex_r.otp);
		c8(CODE_WRITE_ENABLE, 1, 0);
		run({CODE_SECTOR_ERASE, 24'h001000, 8'h0}, 32, 0, 1);
		c8(CODE_OTP_EXIT, 1, 0);
		chk("otp mode left", 0, otp);
		wr_otp(24'h000010, 1);
		chk("program data", 8'hA5, db_r);
		c8(CODE_WRITE_ENABLE, 1, 0);
		c8(CODE_SEC_WRITE, 1, 0);
		chk("security reg", 8'h02, sec);
		wr_otp(24'h000020, 0);
		act_seen = 1'b0;
		sfpf_host_model_i.xfer({CODE_SEC_READ, 32'h0}, 8, 8, rx);
		chk("serial security", 8'h02, rx);
		chk("active on read", 1, act_seen);
		rst_n_in = 1'b0;
		fact = 1'b1;
		repeat (20) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (8) @(negedge mclk_in);
		chk("factory lock", 8'h01, sec);
		sfpf_host_model_i.set_mode(1'b1);
		sfpf_host_model_i.xfer({CODE_SEC_READ, 32'h0}, 8, 8, rx);
		chk("serial security mode3", 8'h01, rx);
		wr_otp(24'h000005, 0);
		wr_otp(24'h000010, 1);
		c8(CODE_WRITE_ENABLE, 1, 0);
		c8(CODE_INDIV_SELECT, 1, 0);
		chk("individual mode", 1, indv);
		c8(CODE_WRITE_ENABLE, 1, 0);
		run({CODE_UNIT_LOCK, 24'h7F3000, 8'h0}, 32, 1, 0);
		c8(CODE_WRITE_ENABLE, 1, 0);
		run({CODE_SECTOR_ERASE, 24'h7F3000, 8'h0}, 32, 0, 1);
		run({CODE_SECTOR_ERASE, 24'h7F4000, 8'h0}, 32, 1, 0);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
